// File: hdl/obc_pkg.sv
package obc_pkg;

   // programming port
   localparam int          OBC_ADDR_W        = 2;
   localparam int          OBC_DATA_W        = 8;
   localparam int          OBC_WORD_W        = 16;
   localparam int          OBC_NUM_BYTES     = 2;

   // register indexes on the programming port
   localparam logic [1:0]  OBC_ADDR_LSB      = 2'h0;
   localparam logic [1:0]  OBC_ADDR_MSB      = 2'h1;
   localparam logic [1:0]  OBC_ADDR_STATUS   = 2'h2;

   // option word field positions
   localparam int          OBC_BIT_OSCILLATOR_SAFEGUARD_ENABLE     = 0;
   localparam int          OBC_BIT_WDHW      = 1;
   localparam int          OBC_BIT_TIMPULL   = 2;
   localparam int          OBC_BIT_NMIPULL   = 3;
   localparam int          OBC_BIT_OSCRC     = 6;
   localparam int          OBC_BIT_PROTECT   = 7;
   localparam int          OBC_BIT_LVD       = 8;
   localparam int          OBC_BIT_STOPWD    = 9;
   localparam int          OBC_RSV_LSB       = 10;
   localparam int          OBC_RSV_MSB       = 15;

   // status register field positions
   localparam int          OBC_ST_PROG_MODE  = 0;
   localparam int          OBC_ST_LSB_DONE   = 1;
   localparam int          OBC_ST_MSB_DONE   = 2;
   localparam int          OBC_ST_RSV_ERR    = 3;

   // erased word, reserved bit mask, idle read data
   localparam logic [15:0] OBC_BLANK_WORD    = 16'h0000;
   localparam logic [15:0] OBC_RSV_MASK      = 16'hFC00;
   localparam logic [7:0]  OBC_RDATA_IDLE    = 8'h00;

   typedef struct packed {
      logic [15:0] otp_word;
      logic [1:0]  byte_done;
      logic        rsv_err;
      logic        prog_mode;
      logic [15:0] cfg;
      logic [7:0]  rdata;
      logic        nmi_q;
      logic        nmi_event;
      logic        stop_grant;
   } obc_state_t;

endpackage

// File: hdl/obc_option_bytes.sv
//Contract
//- two option bytes form configuration word
//- blank part reads all zeros
//- bytes reachable only in programming mode
//- high programming voltage at reset enters programming
//- each byte programs once, then refuses
//- factory coded: fixed word, no readout
//- bit 9 clear: no stop with watchdog
//- bit 9 set: stop allowed if nmi high
//- bit 8 enables low voltage detector
//- nmi recognised on falling edge
//- bit 1 selects hardware watchdog
//- bit 7 blocks program memory readout
//- bit 6 selects rc oscillator
//- bit 0 enables oscillator safeguard
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps

module obc_option_bytes
   import obc_pkg::*;
#(
   parameter bit          FACTORY_CODED = 1'b0,
   parameter logic [15:0] FACTORY_WORD  = 16'h0000
) (
   // clock, reset, enable
   input  wire logic                            CLK,
   input  wire logic                            RESET,
   input  wire logic                            CE,
   // blanks the otp cells, as a fresh part
   input  wire logic                            OTP_ERASE,
   // pins
   input  wire logic                            PROG_VOLTAGE_HIGH,
   input  wire logic                            NMI_PIN,
   // programming port
   input  wire logic [obc_pkg::OBC_ADDR_W-1:0]  PRG_ADDR,
   input  wire logic [obc_pkg::OBC_DATA_W-1:0]  PRG_WDATA,
   input  wire logic                            PRG_WR,
   input  wire logic                            PRG_RD,
   output logic      [obc_pkg::OBC_DATA_W-1:0]  PRG_RDATA,
   // stop control
   input  wire logic                            STOP_REQ,
   input  wire logic                            WATCHDOG_ACTIVE,
   output logic                                 STOP_GRANT,
   output logic                                 NMI_EVENT,
   // decoded configuration
   output logic                                 PROG_MODE,
   output logic                                 STOP_WITH_WATCHDOG_ALLOW,
   output logic                                 LOW_VOLTAGE_DETECT_ENABLE,
   output logic                                 WATCHDOG_HARDWARE_SELECT,
   output logic                                 READOUT_PROTECT,
   output logic                                 OSC_RC_SELECT,
   output logic                                 NMI_PULLUP_ENABLE,
   output logic                                 TIMER_PULLUP_ENABLE,
   output logic                                 OSCILLATOR_SAFEGUARD_ENABLE
);
   import obc_pkg::*;

   obc_state_t st_ff;
   obc_state_t nxt_st;

   // one-hot byte lane for an option byte address, 00 for any other address
   function automatic logic [1:0] byte_sel(input logic [OBC_ADDR_W-1:0] a);
      byte_sel = 2'b00;
      if (a == OBC_ADDR_LSB) begin
         byte_sel = 2'b01;
      end else if (a == OBC_ADDR_MSB) begin
         byte_sel = 2'b10;
      end
   endfunction

   logic [15:0] eff_word;
   logic [1:0]  wr_sel;
   logic [1:0]  rd_sel;
   logic        port_open;

   // factory parts ignore the otp cells entirely
   assign eff_word  = FACTORY_CODED ? FACTORY_WORD : st_ff.otp_word;
   // the port is dead outside programming mode and on factory parts
   assign port_open = st_ff.prog_mode && !FACTORY_CODED && !RESET;
   assign wr_sel    = (PRG_WR && port_open) ? byte_sel(PRG_ADDR) : 2'b00;
   assign rd_sel    = byte_sel(PRG_ADDR);

   always_comb begin
      nxt_st = st_ff;

      // otp cells: only an erase returns them to blank
      if (OTP_ERASE) begin
         nxt_st.otp_word  = OBC_BLANK_WORD;
         nxt_st.byte_done = 2'b00;
         nxt_st.rsv_err   = 1'b0;
      end else begin
         for (int i = 0; i < OBC_NUM_BYTES; i++) begin
            // a programmed byte refuses every further write
            if (wr_sel[i] && !st_ff.byte_done[i]) begin
               nxt_st.otp_word[i*OBC_DATA_W +: OBC_DATA_W] = PRG_WDATA;
               nxt_st.byte_done[i]                         = 1'b1;
            end
         end
         // flag a programmer that sets reserved bits; stored as written
         if (wr_sel[1] && !st_ff.byte_done[1] &&
             ((PRG_WDATA & OBC_RSV_MASK[15:8]) != 8'h00)) begin
            nxt_st.rsv_err = 1'b1;
         end
      end

      // programming voltage is sampled only while reset is held
      if (RESET) begin
         nxt_st.prog_mode = PROG_VOLTAGE_HIGH;
         nxt_st.cfg       = eff_word;
      end

      // read data stand only in the cycle after the read strobe
      nxt_st.rdata = OBC_RDATA_IDLE;
      if (PRG_RD && port_open) begin
         if (rd_sel[0]) begin
            nxt_st.rdata = st_ff.otp_word[7:0];
         end else if (rd_sel[1]) begin
            nxt_st.rdata = st_ff.otp_word[15:8];
         end else if (PRG_ADDR == OBC_ADDR_STATUS) begin
            nxt_st.rdata                   = 8'h00;
            nxt_st.rdata[OBC_ST_PROG_MODE] = st_ff.prog_mode;
            nxt_st.rdata[OBC_ST_LSB_DONE]  = st_ff.byte_done[0];
            nxt_st.rdata[OBC_ST_MSB_DONE]  = st_ff.byte_done[1];
            nxt_st.rdata[OBC_ST_RSV_ERR]   = st_ff.rsv_err;
         end
      end

      // falling edge on the nmi pin gives a one-cycle event
      nxt_st.nmi_q     = NMI_PIN;
      nxt_st.nmi_event = st_ff.nmi_q && !NMI_PIN && !RESET;

      // stop with the watchdog running needs the option and nmi held high
      if (!STOP_REQ || RESET) begin
         nxt_st.stop_grant = 1'b0;
      end else if (!WATCHDOG_ACTIVE) begin
         nxt_st.stop_grant = 1'b1;
      end else if (!st_ff.cfg[OBC_BIT_STOPWD]) begin
         nxt_st.stop_grant = 1'b0;
      end else begin
         nxt_st.stop_grant = NMI_PIN;
      end

      // nmi history presets high and read data clear under reset; cfg keeps loading, otp changes only by erase
      if (RESET) begin
         nxt_st.nmi_q = 1'b1;
         nxt_st.rdata = OBC_RDATA_IDLE;
      end
   end

   // sync reset is handled in the next-state logic so otp cells survive it
   always_ff @(posedge CLK) begin
      if (CE || RESET || OTP_ERASE) begin
         st_ff <= nxt_st;
      end
   end

   assign PRG_RDATA                   = st_ff.rdata;
   assign STOP_GRANT                  = st_ff.stop_grant;
   assign NMI_EVENT                   = st_ff.nmi_event;
   assign PROG_MODE                   = st_ff.prog_mode;
   assign STOP_WITH_WATCHDOG_ALLOW    = st_ff.cfg[OBC_BIT_STOPWD];
   assign LOW_VOLTAGE_DETECT_ENABLE   = st_ff.cfg[OBC_BIT_LVD];
   assign WATCHDOG_HARDWARE_SELECT    = st_ff.cfg[OBC_BIT_WDHW];
   assign READOUT_PROTECT             = st_ff.cfg[OBC_BIT_PROTECT];
   assign OSC_RC_SELECT               = st_ff.cfg[OBC_BIT_OSCRC];
   assign NMI_PULLUP_ENABLE           = st_ff.cfg[OBC_BIT_NMIPULL];
   assign TIMER_PULLUP_ENABLE         = st_ff.cfg[OBC_BIT_TIMPULL];
   assign OSCILLATOR_SAFEGUARD_ENABLE = st_ff.cfg[OBC_BIT_OSCILLATOR_SAFEGUARD_ENABLE];

endmodule

// File: bench/obc_option_bytes_asserts.sv
`timescale 1ns/1ps
module obc_chk (
   // clock, reset
   input wire logic       CLK,
   input wire logic       RESET,
   // pins and requests
   input wire logic       PROG_VOLTAGE_HIGH,
   input wire logic       NMI_PIN,
   input wire logic       PRG_RD,
   input wire logic       STOP_REQ,
   input wire logic       WATCHDOG_ACTIVE,
   // results
   input wire logic [7:0] PRG_RDATA,
   input wire logic       STOP_GRANT,
   input wire logic       NMI_EVENT,
   input wire logic       PROG_MODE,
   input wire logic       STOP_WITH_WATCHDOG_ALLOW
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RESET);
   wire logic wd_stop = STOP_REQ && WATCHDOG_ACTIVE;
   a_stop_block: assert property (wd_stop && !STOP_WITH_WATCHDOG_ALLOW |=> !STOP_GRANT)
      else $error("stop granted");
   a_stop_nmi: assert property (
      wd_stop && STOP_WITH_WATCHDOG_ALLOW |=> STOP_GRANT == $past(NMI_PIN)) else $error("stop");
   a_nmi_edge: assert property ($fell(NMI_PIN) |=> NMI_EVENT)
      else $error("nmi missed");
   a_nmi_quiet: assert property (!$fell(NMI_PIN) |=> !NMI_EVENT)
      else $error("nmi spurious");
   a_cfg_hold: assert property (!RESET |=> $stable({PROG_MODE, STOP_WITH_WATCHDOG_ALLOW}))
      else $error("config moved");
   a_read_closed: assert property (PRG_RD && !PROG_MODE |=> PRG_RDATA == 8'h00)
      else $error("closed read");
   a_rdata_idle: assert property (!PRG_RD |=> PRG_RDATA == 8'h00)
      else $error("read data lingers");
   a_prog_entry: assert property ($fell(RESET) |-> PROG_MODE == $past(PROG_VOLTAGE_HIGH))
      else $error("prog mode entry");
endmodule
bind obc_option_bytes obc_chk u_chk (.CLK(CLK), .RESET(RESET), .NMI_PIN(NMI_PIN),
   .PROG_VOLTAGE_HIGH(PROG_VOLTAGE_HIGH), .PRG_RD(PRG_RD), .STOP_REQ(STOP_REQ),
   .WATCHDOG_ACTIVE(WATCHDOG_ACTIVE), .PRG_RDATA(PRG_RDATA), .STOP_GRANT(STOP_GRANT),
   .NMI_EVENT(NMI_EVENT), .PROG_MODE(PROG_MODE),
   .STOP_WITH_WATCHDOG_ALLOW(STOP_WITH_WATCHDOG_ALLOW));

// File: bench/obc_prog_tool.sv
`timescale 1ns/1ps
module obc_prog_tool (
   // clock, read data
   input wire logic       clk,
   input wire logic [7:0] rdata,
   // programming port, supply pin
   output logic [1:0]     addr,
   output logic [7:0]     wdata,
   output logic           wr,
   output logic           rd,
   output logic           vpp = 1'b0 // grounded unless asking for programming
);
   initial {addr, wdata, wr, rd} = 12'h000;
   task automatic put(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      {addr, wdata, wr} <= {a, v, 1'b1};
      @(posedge clk);
      {wdata, wr} <= {~v, 1'b0}; // released data must not echo the last value
   endtask
   task automatic get(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import obc_pkg::*;
   localparam logic [15:0] W   = 16'h03C3;
   localparam logic [15:0] FW  = 16'h0141;
   localparam logic [7:0]  FCFG = {FW[9], FW[8], FW[1], FW[7], FW[6], FW[3], FW[2], FW[0]};
   localparam logic [7:0]  CFG = {W[9], W[8], W[1], W[7], W[6], W[3], W[2], W[0]};
   localparam logic [31:0] TBL = {8'h00, 8'h07, W};
   logic       clk = 1'b0, rst = 1'b1, erase = 1'b1, nmi = 1'b1, sreq = 1'b0, wdog = 1'b0;
   logic [7:0] d;
   wire logic  wr, rd, vpp, grant, pm, nev;
   wire logic [7:0] rdf, cfg_f;
   wire logic [1:0] addr;
   wire logic [7:0] wdata, rdata, cfg;
   int         fail_count = 0, num_checks = 0, cycles = 0;
   obc_prog_tool tool (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .vpp(vpp));
   obc_option_bytes dut (.CLK(clk), .RESET(rst), .CE(1'b1), .OTP_ERASE(erase),
      .PROG_VOLTAGE_HIGH(vpp), .NMI_PIN(nmi), .PRG_ADDR(addr), .PRG_WDATA(wdata), .PRG_WR(wr),
      .PRG_RD(rd), .PRG_RDATA(rdata), .STOP_REQ(sreq), .WATCHDOG_ACTIVE(wdog),
      .STOP_GRANT(grant), .NMI_EVENT(nev), .PROG_MODE(pm), .STOP_WITH_WATCHDOG_ALLOW(cfg[7]),
      .LOW_VOLTAGE_DETECT_ENABLE(cfg[6]), .WATCHDOG_HARDWARE_SELECT(cfg[5]),
      .READOUT_PROTECT(cfg[4]), .OSC_RC_SELECT(cfg[3]), .NMI_PULLUP_ENABLE(cfg[2]),
      .TIMER_PULLUP_ENABLE(cfg[1]), .OSCILLATOR_SAFEGUARD_ENABLE(cfg[0]));
   // factory coded twin: fixed word, port never opens
   obc_option_bytes #(.FACTORY_CODED(1'b1), .FACTORY_WORD(FW)) dut_f (.CLK(clk), .RESET(rst),
      .CE(1'b1), .OTP_ERASE(erase), .PROG_VOLTAGE_HIGH(vpp), .NMI_PIN(nmi), .PRG_ADDR(addr),
      .PRG_WDATA(wdata), .PRG_WR(wr), .PRG_RD(rd), .PRG_RDATA(rdf), .STOP_REQ(sreq),
      .WATCHDOG_ACTIVE(wdog), .STOP_GRANT(), .NMI_EVENT(), .PROG_MODE(),
      .STOP_WITH_WATCHDOG_ALLOW(cfg_f[7]), .LOW_VOLTAGE_DETECT_ENABLE(cfg_f[6]),
      .WATCHDOG_HARDWARE_SELECT(cfg_f[5]), .READOUT_PROTECT(cfg_f[4]),
      .OSC_RC_SELECT(cfg_f[3]), .NMI_PULLUP_ENABLE(cfg_f[2]), .TIMER_PULLUP_ENABLE(cfg_f[1]),
      .OSCILLATOR_SAFEGUARD_ENABLE(cfg_f[0]));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles > 2000) begin
         fail_count++;
         test_done();
      end
   end
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic do_reset(input int n, input logic v);
      @(posedge clk);
      rst <= 1'b1;
      tool.vpp <= v;
      repeat (n) @(posedge clk);
      {rst, erase} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic stop(input logic w, input logic n, input logic e);
      logic f;
      f = nmi & ~n;
      @(posedge clk);
      {sreq, wdog, nmi} <= {1'b1, w, n};
      @(posedge clk);
      @(negedge clk);
      chk("stop grant", {7'h00, e}, {7'h00, grant});
      chk("nmi event", {7'h00, f}, {7'h00, nev});
   endtask
   initial begin
      do_reset(10, 1'b0);
      chk("blank config", 8'h00, cfg);
      chk("factory config", FCFG, cfg_f);
      chk("prog mode", 8'h00, {7'h00, pm});
      tool.put(OBC_ADDR_LSB, 8'hFF);
      tool.get(OBC_ADDR_LSB, d);
      chk("closed read", 8'h00, d);
      stop(1'b1, 1'b1, 1'b0);
      stop(1'b0, 1'b1, 1'b1);
      do_reset(2, 1'b1);
      chk("prog mode", 8'h01, {7'h00, pm});
      tool.put(OBC_ADDR_LSB, W[7:0]);
      tool.put(OBC_ADDR_MSB, W[15:8]); // reserved top bits sent as zero
      tool.put(OBC_ADDR_LSB, ~W[7:0]);
      for (int a = 0; a < 4; a++) begin
         tool.get(a[1:0], d);
         chk("port read", TBL[a*8 +: 8], d);
         chk("factory read", 8'h00, rdf);
      end
      chk("config early", 8'h00, cfg);
      do_reset(2, 1'b0);
      chk("config", CFG, cfg);
      tool.get(OBC_ADDR_STATUS, d);
      chk("closed status", 8'h00, d);
      stop(1'b1, 1'b1, 1'b1);
      stop(1'b1, 1'b0, 1'b0);
      test_done();
   end
endmodule
